// ### hw/mfm_pkg.sv
// Package for the motor fault manager: alarm codes, lamp timing, command codes.
// Assumes a single 250 MHz core clock.
package mfm_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned BLINK_ON_MS     = 200;
  localparam int unsigned BLINK_GAP_MS    = 1000;
  localparam int unsigned BLINK_ON_CYC    = BLINK_ON_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_GAP_CYC   = BLINK_GAP_MS * 1000 * CLK_MHZ;
  localparam int unsigned HIST_DEPTH      = 10;

  localparam logic [7:0] ALM_NONE         = 8'h00;
  localparam logic [7:0] ALM_POS_DEV      = 8'h10;
  localparam logic [7:0] ALM_POS_DEV_OFF  = 8'h12;
  localparam logic [7:0] ALM_OVERCURRENT  = 8'h20;
  localparam logic [7:0] ALM_MAIN_OFF     = 8'h23;
  localparam logic [7:0] ALM_OVERTRAVEL   = 8'h66;
  localparam logic [7:0] ALM_ABS_POS      = 8'h65;
  localparam logic [3:0] BLINK_POS_DEV    = 4'h4;
  localparam logic [3:0] BLINK_OVERCUR    = 4'h5;
  localparam logic [3:0] BLINK_MAIN_OFF   = 4'h3;
  localparam logic [3:0] BLINK_OVERTRAVEL = 4'h7;
  localparam logic [3:0] BLINK_OTHER      = 4'h1;

  // Serial command codes, as decoded by the link front end
  localparam logic [2:0] CMD_NONE         = 3'h0;
  localparam logic [2:0] CMD_ALARM_RESET  = 3'h1;
  localparam logic [2:0] CMD_ABS_RESET    = 3'h2;
  localparam logic [2:0] CMD_HIST_READ    = 3'h3;
  localparam logic [2:0] CMD_HIST_CLEAR   = 3'h4;
  localparam logic [2:0] CMD_CODE_READ    = 3'h5;

  typedef enum logic [1:0] {
    MFM_LAMP_IDLE = 2'b00,
    MFM_LAMP_ON   = 2'b01,
    MFM_LAMP_OFF  = 2'b10,
    MFM_LAMP_GAP  = 2'b11
  } mfm_lamp_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] cmd;
    logic [3:0] index;
  } mfm_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mfm_rsp_s;

  typedef struct packed {
    logic pos_dev;
    logic pos_dev_off_warn;
    logic short_circuit;
    logic main_power_ok;
    logic start_req;
    logic overtravel;
    logic abs_pos_err;
    logic current_on;
  } mfm_cond_s;
endpackage

// ### hw/mfm_fault_manager.sv
// Motor fault manager: alarm latch, lamp blink coder, alarm history, serial
// command decode, warning output and a sticky interrupt with a mask.
// Assumes the serial front end delivers one-cycle command pulses on the core
// clock; the history array stands for the nonvolatile store behind it.
// How it works
// - Alarm drops alarm output and stops motor
// - Lamp blinks code-specific count per group
// - Clear on falling edge of clear input
// - Serial, tool reset and power cycle clear
// - Absolute error clears only by own paths or power cycle
// - Ten entry history, newest first, drop oldest
// - History read command returns stored entries
// - History clear command erases all entries
// - Warning precedes alarm and never stops motor
// - Position deviation at current on raises 10h
// - Current on during off-warning raises 12h
// - Start without main power raises 23h
// - Short circuit raises 20h
`timescale 1ns/100ps
module mfm_fault_manager #(
  parameter int unsigned DEPTH    = mfm_pkg::HIST_DEPTH,
  parameter int unsigned ON_CYC   = mfm_pkg::BLINK_ON_CYC,
  parameter int unsigned GAP_CYC  = mfm_pkg::BLINK_GAP_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire mfm_pkg::mfm_cond_s i_cond,
  input  wire logic              i_pos_dev_warn,
  input  wire logic              i_fault_clear_input,
  input  wire logic              i_position_error_clear_input,
  input  wire logic              i_tool_reset,
  input  wire mfm_pkg::mfm_cmd_s i_cmd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic [7:0]             o_reg_rdata,
  output mfm_pkg::mfm_rsp_s      o_rsp,
  output logic                   o_alarm_output,
  output logic                   o_motor_stop,
  output logic                   o_fault_lamp,
  output logic                   o_warning_output,
  output logic                   o_irq
);
  import mfm_pkg::*;

  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h01;
  localparam logic [7:0] REG_CODE   = 8'h02;
  localparam logic [7:0] REG_COUNT  = 8'h03;
  localparam int unsigned CW = $clog2(GAP_CYC + 1);

  typedef struct packed {
    logic [1:0]        fclr_sync;
    logic [1:0]        pclr_sync;
    logic [7:0]        cond_sync0;
    logic [7:0]        cond_sync1;
    logic              warn_s0;
    logic              warn_s1;
    logic              fclr_d;
    logic              pclr_d;
    logic              con_d;
    logic [7:0]        code;
    logic              abs_alarm;
    mfm_lamp_e         lamp_st;
    logic [3:0]        blinks;
    logic [CW-1:0]     timer;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic [7:0]        rdata;
    mfm_rsp_s          rsp;
  } mfm_state_s;

  mfm_state_s st;
  mfm_state_s next_st;
  logic [7:0] hist [DEPTH];
  logic [7:0] raise_code;
  logic       raise;
  logic [3:0] want_blinks;
  logic       fclr_fall;
  logic       pclr_fall;
  logic       abs_clear;
  logic       gen_clear;
  logic       hist_push;
  logic       hist_wipe;
  // History fill level, kept apart from the reset state on purpose
  logic [3:0] hist_cnt;
  logic [3:0] next_hist_cnt;
  mfm_cond_s  c;

  always_comb begin
    c = mfm_cond_s'(st.cond_sync1);
    fclr_fall = st.fclr_d & ~st.fclr_sync[1];
    pclr_fall = st.pclr_d & ~st.pclr_sync[1];
    gen_clear = fclr_fall | i_tool_reset |
                (i_cmd.valid && i_cmd.cmd == CMD_ALARM_RESET);
    abs_clear = pclr_fall | (i_cmd.valid && i_cmd.cmd == CMD_ABS_RESET);
    raise = 1'b1;
    raise_code = ALM_NONE;
    if (c.short_circuit) begin
      raise_code = ALM_OVERCURRENT;
    end else if (c.current_on && c.pos_dev) begin
      raise_code = ALM_POS_DEV;
    end else if (c.current_on && !st.con_d && c.pos_dev_off_warn) begin
      raise_code = ALM_POS_DEV_OFF;
    end else if (c.start_req && !c.main_power_ok) begin
      raise_code = ALM_MAIN_OFF;
    end else if (c.overtravel) begin
      raise_code = ALM_OVERTRAVEL;
    end else if (c.abs_pos_err) begin
      raise_code = ALM_ABS_POS;
    end else begin
      raise = 1'b0;
    end
    // First alarm wins; later ones wait until it is cleared
    hist_push = raise && st.code == ALM_NONE;
    hist_wipe = i_cmd.valid && i_cmd.cmd == CMD_HIST_CLEAR;
    case (raise_code)
      ALM_POS_DEV: begin
        want_blinks = BLINK_POS_DEV;
      end
      ALM_POS_DEV_OFF: begin
        want_blinks = BLINK_POS_DEV;
      end
      ALM_OVERCURRENT: begin
        want_blinks = BLINK_OVERCUR;
      end
      ALM_MAIN_OFF: begin
        want_blinks = BLINK_MAIN_OFF;
      end
      ALM_OVERTRAVEL: begin
        want_blinks = BLINK_OVERTRAVEL;
      end
      default: begin
        want_blinks = BLINK_OTHER;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.fclr_sync = {st.fclr_sync[0], i_fault_clear_input};
    next_st.pclr_sync = {st.pclr_sync[0], i_position_error_clear_input};
    next_st.cond_sync0 = i_cond;
    next_st.cond_sync1 = st.cond_sync0;
    next_st.warn_s0 = i_pos_dev_warn;
    next_st.warn_s1 = st.warn_s0;
    next_st.fclr_d = st.fclr_sync[1];
    next_st.pclr_d = st.pclr_sync[1];
    next_st.con_d = c.current_on;
    next_st.rsp = '{valid: 1'b0, data: 8'h00};
    next_st.rdata = 8'h00;

    // Clearing the latch: absolute error only by its own paths
    if (st.code != ALM_NONE) begin
      if (st.abs_alarm ? abs_clear : gen_clear) begin
        next_st.code = ALM_NONE;
        next_st.abs_alarm = 1'b0;
        next_st.status[1] = 1'b1;
      end
    end else if (raise) begin
      next_st.code = raise_code;
      next_st.abs_alarm = (raise_code == ALM_ABS_POS);
      next_st.status[0] = 1'b1;
      next_st.lamp_st = MFM_LAMP_ON;
      next_st.blinks = want_blinks;
      next_st.timer = CW'(ON_CYC);
    end

    // Count saturates at the depth; the oldest entry simply falls off
    next_hist_cnt = hist_cnt;
    if (hist_wipe) begin
      next_hist_cnt = 4'h0;
    end else if (hist_push && hist_cnt < 4'(DEPTH)) begin
      next_hist_cnt = hist_cnt + 4'h1;
    end

    // Lamp blink coder: N pulses, then a long gap, repeated
    if (st.code == ALM_NONE && !raise) begin
      next_st.lamp_st = MFM_LAMP_IDLE;
    end else if (!(st.code == ALM_NONE)) begin
      if (st.timer != '0) begin
        next_st.timer = st.timer - CW'(1);
      end else begin
        case (st.lamp_st)
          MFM_LAMP_ON: begin
            next_st.lamp_st = MFM_LAMP_OFF;
            next_st.timer = CW'(ON_CYC);
          end
          MFM_LAMP_OFF: begin
            if (st.blinks > 4'h1) begin
              next_st.blinks = st.blinks - 4'h1;
              next_st.lamp_st = MFM_LAMP_ON;
              next_st.timer = CW'(ON_CYC);
            end else begin
              next_st.lamp_st = MFM_LAMP_GAP;
              next_st.timer = CW'(GAP_CYC);
            end
          end
          MFM_LAMP_GAP: begin
            next_st.lamp_st = MFM_LAMP_ON;
            next_st.blinks = want_code_blinks(st.code);
            next_st.timer = CW'(ON_CYC);
          end
          default: begin
            next_st.lamp_st = MFM_LAMP_IDLE;
          end
        endcase
      end
    end

    if (i_cmd.valid && i_cmd.cmd == CMD_HIST_READ) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = (i_cmd.index < hist_cnt && i_cmd.index < 4'(DEPTH)) ?
                         hist[i_cmd.index] : 8'h00;
    end else if (i_cmd.valid && i_cmd.cmd == CMD_CODE_READ) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = st.code;
    end

    // Register port; set wins over write-one-clear unless the bit was already set
    if (i_reg_wr) begin
      case (i_reg_addr)
        REG_STATUS: begin
          next_st.status = next_st.status &
                           ~(i_reg_wdata[1:0] & ~(next_st.status ^ st.status));
        end
        REG_MASK: begin
          next_st.mask = i_reg_wdata[1:0];
        end
        default: begin
          next_st.mask = next_st.mask;
        end
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        REG_STATUS: begin
          next_st.rdata = {6'h00, st.status};
        end
        REG_MASK: begin
          next_st.rdata = {6'h00, st.mask};
        end
        REG_CODE: begin
          next_st.rdata = st.code;
        end
        REG_COUNT: begin
          next_st.rdata = {4'h0, hist_cnt};
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  function automatic logic [3:0] want_code_blinks(input logic [7:0] code);
    case (code)
      ALM_POS_DEV: begin
        return BLINK_POS_DEV;
      end
      ALM_POS_DEV_OFF: begin
        return BLINK_POS_DEV;
      end
      ALM_OVERCURRENT: begin
        return BLINK_OVERCUR;
      end
      ALM_MAIN_OFF: begin
        return BLINK_MAIN_OFF;
      end
      ALM_OVERTRAVEL: begin
        return BLINK_OVERTRAVEL;
      end
      default: begin
        return BLINK_OTHER;
      end
    endcase
  endfunction

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Fill level is as persistent as the entries it counts; a core reset
  // must not make stored records unreadable
  always_ff @(posedge i_core_clk) begin
    hist_cnt <= next_hist_cnt;
  end

  // History shift register, newest at index 0; survives core reset
  generate
    for (genvar gi = 0; gi < DEPTH; gi++) begin : g_hist
      always_ff @(posedge i_core_clk) begin
        if (hist_wipe) begin
          hist[gi] <= 8'h00;
        end else if (hist_push) begin
          if (gi == 0) begin
            hist[gi] <= raise_code;
          end else begin
            hist[gi] <= hist[gi-1];
          end
        end
      end
    end
  endgenerate

  assign o_alarm_output   = (st.code == ALM_NONE);
  assign o_motor_stop     = (st.code != ALM_NONE);
  assign o_fault_lamp     = (st.lamp_st == MFM_LAMP_ON);
  assign o_warning_output = st.warn_s1;
  assign o_reg_rdata      = st.rdata;
  assign o_rsp            = st.rsp;
  assign o_irq            = |(st.status & st.mask);
endmodule // mfm_fault_manager

// ### bench/mfm_chk.sv
// Checker on the fault manager top ports, bound into every instance.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/100ps
module mfm_chk (
  input wire logic               i_core_clk,
  input wire logic               i_rst_b,
  input wire mfm_pkg::mfm_cond_s i_cond,
  input wire logic               i_pos_dev_warn,
  input wire logic               i_fault_clear_input,
  input wire logic               i_position_error_clear_input,
  input wire logic               i_tool_reset,
  input wire mfm_pkg::mfm_cmd_s  i_cmd,
  input wire logic [7:0]         i_reg_addr,
  input wire logic [7:0]         i_reg_wdata,
  input wire logic               i_reg_wr,
  input wire logic               i_reg_rd,
  input wire logic [7:0]         o_reg_rdata,
  input wire mfm_pkg::mfm_rsp_s  o_rsp,
  input wire logic               o_alarm_output,
  input wire logic               o_motor_stop,
  input wire logic               o_fault_lamp,
  input wire logic               o_warning_output,
  input wire logic               o_irq
);
  import mfm_pkg::*;
  // Recent clear causes; the synchroniser delays a pin fall by three edges
  logic [5:0] clr_seen;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) clr_seen <= '0;
    else clr_seen <= {clr_seen[4:0], $fell(i_fault_clear_input) | $fell(i_position_error_clear_input) |
      i_tool_reset | (i_cmd.valid && (i_cmd.cmd == CMD_ALARM_RESET || i_cmd.cmd == CMD_ABS_RESET))};
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_alarm_stop_pair: assert property (o_alarm_output != o_motor_stop)
    else $error("alarm output and motor stop disagree");
  a_lamp_starts: assert property ($fell(o_alarm_output) |-> ##[0:8] o_fault_lamp)
    else $error("lamp did not start with alarm");
  a_lamp_quiet: assert property (o_alarm_output [*8] |-> !o_fault_lamp)
    else $error("lamp lit without alarm");
  a_short_raises: assert property (o_alarm_output && $rose(i_cond.short_circuit) |-> ##[2:5] !o_alarm_output)
    else $error("short circuit not latched");
  a_hold_till_clear: assert property ($rose(o_alarm_output) |-> clr_seen != '0)
    else $error("alarm dropped without clear");
  a_no_clear_rise: assert property ($rose(i_fault_clear_input) && !o_alarm_output |=>
    (!o_alarm_output || clr_seen != '0) [*3])
    else $error("alarm cleared on rising clear input");
  a_rsp_on_read: assert property (i_cmd.valid && (i_cmd.cmd == CMD_HIST_READ || i_cmd.cmd == CMD_CODE_READ)
    |=> o_rsp.valid)
    else $error("read command without answer");
  a_rsp_only_read: assert property (o_rsp.valid |-> $past(i_cmd.valid) &&
    ($past(i_cmd.cmd) == CMD_HIST_READ || $past(i_cmd.cmd) == CMD_CODE_READ))
    else $error("answer without read command");
  a_warn_delay: assert property ($past(i_rst_b, 2) |-> o_warning_output == $past(i_pos_dev_warn, 2))
    else $error("warning output not following input");
  c_alarm: cover property ($fell(o_alarm_output));
  c_rsp: cover property (o_rsp.valid);
  c_irq: cover property (o_irq);
endmodule // mfm_chk
bind mfm_fault_manager mfm_chk mfm_chk_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cond(i_cond),
  .i_pos_dev_warn(i_pos_dev_warn), .i_fault_clear_input(i_fault_clear_input), .i_tool_reset(i_tool_reset),
  .i_position_error_clear_input(i_position_error_clear_input), .i_cmd(i_cmd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_rsp(o_rsp),
  .o_alarm_output(o_alarm_output), .o_motor_stop(o_motor_stop), .o_fault_lamp(o_fault_lamp),
  .o_warning_output(o_warning_output), .o_irq(o_irq));

// ### bench/mfm_host.sv
// Host side of the serial link: one-cycle commands, takes the answer.
// Assumes callers enter xfer right after a rising core clock edge.
`timescale 1ns/100ps
module mfm_host (
  input  wire logic              i_core_clk,
  input  wire mfm_pkg::mfm_rsp_s i_rsp,
  output mfm_pkg::mfm_cmd_s      o_cmd
);
  import mfm_pkg::*;
  initial o_cmd = '0;
  task automatic xfer(input logic [2:0] c, input logic [3:0] idx, output logic [7:0] d);
    @(posedge i_core_clk);
    o_cmd <= '{valid: 1'b1, cmd: c, index: idx};
    @(posedge i_core_clk);
    // Idle index flips so a stale value never looks valid
    o_cmd <= '{valid: 1'b0, cmd: CMD_NONE, index: ~idx};
    @(posedge i_core_clk);
    d = i_rsp.valid ? i_rsp.data : 8'hxx;
  endtask
endmodule // mfm_host

// ### bench/tb.sv
// Bench: queue model of alarm code and history against the fault manager.
// Assumes short blink counts; the host model sends serial commands.
`timescale 1ns/100ps
module tb;
  import mfm_pkg::*;
  logic        clk = 0, rst_b = 0, fc = 0, pc = 0, tr = 0, wr = 0, rd = 0, wn = 0;
  logic [7:0]  ad = 0, wd = 0, rdat, d;
  logic        alarm_output, stp, lmp, wo, irq;
  mfm_cond_s   cnd = 8'h10;
  mfm_cmd_s    cmd;
  mfm_rsp_s    rsp;
  logic [31:0] lf = 32'he80e1292;
  int          fail_count = 0, comparisons = 0, cyc = 0, q[$];
  logic [7:0]  tc[5] = '{8'h30, 8'h91, 8'h51, 8'h08, 8'h14};
  logic [7:0]  te[5] = '{ALM_OVERCURRENT, ALM_POS_DEV, ALM_POS_DEV_OFF, ALM_MAIN_OFF, ALM_OVERTRAVEL};
  logic [3:0]  tn[5] = '{BLINK_OVERCUR, BLINK_POS_DEV, 4'h0, BLINK_MAIN_OFF, BLINK_OVERTRAVEL};
  always #2 clk = ~clk;
  mfm_fault_manager #(.ON_CYC(4), .GAP_CYC(16)) mfm_fault_manager_i (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_cond(cnd), .i_pos_dev_warn(wn), .i_fault_clear_input(fc), .i_position_error_clear_input(pc),
    .i_tool_reset(tr), .i_cmd(cmd), .i_reg_addr(ad), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdat), .o_rsp(rsp), .o_alarm_output(alarm_output), .o_motor_stop(stp), .o_fault_lamp(lmp),
    .o_warning_output(wo), .o_irq(irq));
  mfm_host mfm_host_i (.i_core_clk(clk), .i_rsp(rsp), .o_cmd(cmd));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Inputs are read at an edge, before the design's updates land
  task automatic acc(input logic w, input logic [7:0] a, v);
    @(posedge clk);
    ad <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    @(posedge clk);
    d = rdat;
  endtask
  task automatic code(input logic [7:0] e);
    acc(0, 8'h02, 8'h00);
    cmp(d, e);
    mfm_host_i.xfer(CMD_CODE_READ, 4'h0, d);
    cmp(d, e);
    acc(0, 8'h03, 8'h00);
    cmp(d, 8'(q.size()));
  endtask
  task automatic raise(input logic [7:0] c, e, input logic [3:0] n);
    int r, k;
    logic p;
    r = 0;
    k = 0;
    p = 0;
    @(posedge clk);
    cnd <= c;
    if (n == 0) tick(8);
    else begin
      while (!lmp && k < 40) begin
        @(posedge clk);
        k++;
      end
      // Window ends before the next group can start
      // One blink is 2*(ON_CYC+1) cycles; the gap keeps the next group out
      repeat (10 * n) begin
        if (lmp && !p) r++;
        p = lmp;
        @(posedge clk);
      end
      cmp(8'(r), {4'h0, n});
    end
    cnd <= 8'h10;
    cmp({7'h0, stp}, 8'h01);
    cmp({7'h0, alarm_output}, 8'h00);
    q.push_front(e);
    if (q.size() > HIST_DEPTH) q.pop_back();
    code(e);
  endtask
  // 0 clear input, 1 tool reset, 2 reset command, 3 position clear, 4 abs command
  task automatic clr(input int h);
    @(posedge clk);
    fc <= (h == 0);
    pc <= (h == 3);
    tr <= (h == 1);
    if (h == 2) mfm_host_i.xfer(CMD_ALARM_RESET, 4'h0, d);
    if (h == 4) mfm_host_i.xfer(CMD_ABS_RESET, 4'h0, d);
    @(posedge clk);
    tr <= 0;
    tick(6);
    fc <= 0;
    pc <= 0;
    tick(8);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    tick(16);
    rst_b <= 1;
    mfm_host_i.xfer(CMD_HIST_CLEAR, 4'h0, d);
    acc(1, 8'h00, 8'hff);
    code(8'h00);
    for (int i = 0; i < 5; i++) begin
      raise(tc[i], te[i], tn[i]);
      clr(i % 3);
      code(8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      acc(1, 8'h01, lf[7:0]);
      tick(2);
      cmp({7'h0, irq}, {7'h0, |lf[1:0]});
    end
    acc(1, 8'h01, 8'h03);
    acc(1, 8'h00, 8'h01);
    acc(0, 8'h00, 8'h00);
    cmp(d, 8'h02);
    acc(1, 8'h00, 8'h02);
    tick(2);
    cmp({7'h0, irq}, 8'h00);
    acc(1, 8'h7f, 8'h5a);
    acc(0, 8'h7f, 8'h00);
    cmp(d, 8'h00);
    raise(8'h12, ALM_ABS_POS, BLINK_OTHER);
    for (int h = 0; h < 3; h++) begin
      clr(h);
      code(ALM_ABS_POS);
    end
    clr(3);
    code(8'h00);
    raise(8'h12, ALM_ABS_POS, 4'h0);
    clr(4);
    code(8'h00);
    @(posedge clk);
    wn <= 1;
    tick(4);
    cmp({7'h0, wo}, 8'h01);
    cmp({7'h0, stp}, 8'h00);
    wn <= 0;
    for (int i = 0; i < 6; i++) begin
      raise(tc[i % 5], te[i % 5], 4'h0);
      clr(1);
    end
    for (int i = 0; i < 10; i++) begin
      mfm_host_i.xfer(CMD_HIST_READ, 4'(i), d);
      cmp(d, 8'(q[i]));
    end
    lf = nxt(lf);
    mfm_host_i.xfer(CMD_HIST_READ, 4'(10 + lf[2:0] % 6), d);
    cmp(d, 8'h00);
    raise(8'h30, ALM_OVERCURRENT, 4'h0);
    rst_b <= 0;
    tick(3);
    rst_b <= 1;
    code(8'h00);
    mfm_host_i.xfer(CMD_HIST_CLEAR, 4'h0, d);
    q.delete();
    code(8'h00);
    summarize();
  end
endmodule // tb
